// ### verif/acs_core_model.sv
// Behavioural analog core: answers calibration and sampling after a set delay
module acs_core_model
    import acs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire acs_pkg::acs_core_ctl_type core_ctl_i,
    input wire logic [4:0] dly_i,
    output acs_pkg::acs_core_rsp_type core_rsp_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic req_q;
    logic [5:0] cnt_q;
    logic [11:0] res_q;
    wire req = core_ctl_i.cal_run || core_ctl_i.sample;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_q <= 1'b0;
            cnt_q <= 6'h00;
            res_q <= 12'h000;
        end else begin
            req_q <= req;
            if (core_ctl_i.power_down) begin
                cnt_q <= 6'h00;
            end else if (req && (!req_q || cnt_q <= 6'h01)) begin
                // A request that stays high asks for the next conversion
                cnt_q <= {1'b0, dly_i} + 6'h04;
            end else if (cnt_q != 6'h00) begin
                cnt_q <= cnt_q - 6'h01;
            end
            // Channel is taken late, after the select has settled for the new slot
            if (cnt_q == 6'h03) begin
                res_q <= {core_ctl_i.channel, 7'h35};
            end
        end
    end
    // Done stands one converter clock at the default divider, so it is counted once
    assign core_rsp_o.done = (cnt_q != 6'h00) && (cnt_q <= 6'h02);
    // Outside done the result wanders, so a late sample cannot look right
    assign core_rsp_o.result = core_rsp_o.done ? res_q : {~res_q[11:6], cnt_q};
endmodule

// ### verif/acs_top_checker.sv
// Port-level assertions for the converter control block
module acs_top_checker
    import acs_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire acs_pkg::acs_apb_req_type apb_req_i,
    input wire acs_pkg::acs_apb_rsp_type apb_rsp_o,
    input wire acs_pkg::acs_core_ctl_type core_ctl_o,
    input wire acs_pkg::acs_core_rsp_type core_rsp_i,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic on_q;
    wire acc = apb_req_i.psel && apb_req_i.penable;
    wire ctl_wr = acc && apb_req_i.pwrite && (apb_req_i.paddr == ACS_OFS_CTL);
    wire ctl_rd = acc && !apb_req_i.pwrite && (apb_req_i.paddr == ACS_OFS_CTL);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Tracks enable as written, so a start in the power-on write itself is not expected to run
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            on_q <= 1'b0;
        end else if (ctl_wr) begin
            on_q <= apb_req_i.pwdata[ACS_CTL_ON_BIT];
        end
    end
    chk_zero_wait_ready: assert property (acc |-> apb_rsp_o.pready)
        else $error("access phase without ready");
    chk_unmapped_err: assert property (acc && apb_req_i.paddr > ACS_OFS_CAL
        |-> apb_rsp_o.pslverr && apb_rsp_o.prdata == ACS_UNMAPPED_RDATA)
        else $error("unmapped access not refused");
    chk_cal_launch: assert property (ctl_wr && on_q && apb_req_i.pwdata[0]
        && apb_req_i.pwdata[ACS_CTL_CAL_START_BIT] |-> ##[1:3] core_ctl_o.cal_run)
        else $error("calibration did not start");
    chk_cal_reads_one: assert property (ctl_rd && core_ctl_o.cal_run
        && !$past(core_rsp_i.done) && !core_rsp_i.done
        |-> apb_rsp_o.prdata[ACS_CTL_CAL_START_BIT])
        else $error("start bit low during calibration");
    chk_cal_ends: assert property (core_ctl_o.cal_run && core_rsp_i.done
        |-> ##[1:4] !core_ctl_o.cal_run)
        else $error("calibration did not end");
    chk_cal_clear_pulse: assert property (ctl_wr && on_q && apb_req_i.pwdata[0]
        && apb_req_i.pwdata[ACS_CTL_CAL_RESET_BIT] |-> ##[1:3] core_ctl_o.cal_clear)
        else $error("calibration reset not passed on");
    chk_off_quiet: assert property (core_ctl_o.power_down
        |-> !core_ctl_o.cal_run && !core_ctl_o.sample && core_ctl_o.cal_clear)
        else $error("activity while converter off");
    chk_off_power_down: assert property (ctl_wr && !apb_req_i.pwdata[0]
        |-> ##[1:3] core_ctl_o.power_down)
        else $error("analog part not powered down");
    chk_channel_range: assert property (core_ctl_o.sample
        |-> core_ctl_o.channel < ACS_CHANNELS)
        else $error("channel out of range");
    cov_cal: cover property ($rose(core_ctl_o.cal_run));
    cov_sample: cover property ($rose(core_ctl_o.sample));
    cov_irq: cover property ($rose(irq_o));
    cov_err: cover property (acc && apb_rsp_o.pslverr);
endmodule

// ### verif/acs_top_tb_top.sv
// Self-checking bench for the converter control block
module acs_top_tb_top;
    import acs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i;
    logic rst_n_i;
    logic hw_trigger_i;
    logic irq_o;
    logic [4:0] dly;
    acs_apb_req_type req;
    acs_apb_rsp_type rsp;
    acs_core_ctl_type ctl;
    acs_core_rsp_type crsp;
    logic [31:0] rdv;
    logic errv;
    int n_mismatch;
    int check_count;
    acs_top i_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .apb_req_i(req),
        .apb_rsp_o(rsp), .hw_trigger_i(hw_trigger_i), .core_ctl_o(ctl),
        .core_rsp_i(crsp), .irq_o(irq_o));
    acs_core_model i_core (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .core_ctl_i(ctl),
        .dly_i(dly), .core_rsp_o(crsp));
    always #10 clk_sys_i = ~clk_sys_i;
    task automatic summarize();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_sys_i);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
        @(posedge clk_sys_i);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            n_mismatch++;
            summarize();
        end
        rdv = rsp.prdata;
        errv = rsp.pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic poll(input logic [7:0] a, input int b, input logic v);
        int n;
        n = 0;
        do begin
            xfer(1'b0, a, 32'h0);
            n++;
        end while (rdv[b] !== v && n < 200);
        chk({31'h0, rdv[b]}, {31'h0, v});
        if (n >= 200) begin
            summarize();
        end
    endtask
    function automatic logic [15:0] exp_data(input logic [4:0] ch, input logic left);
        logic [11:0] r;
        r = {ch, 7'h35};
        return left ? {r, 4'h0} : {4'h0, r};
    endfunction
    initial begin
        logic [4:0] ch;
        logic [3:0] len;
        logic [31:0] cw;
        clk_sys_i = 1'b0;
        rst_n_i = 1'b0;
        hw_trigger_i = 1'b0;
        dly = 5'h03;
        req = '0;
        void'($urandom(32'h4f47f3de));
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        xfer(1'b0, ACS_OFS_CTL, 32'h0);
        chk(rdv, ACS_RST_VALUE);
        chk({31'h0, ctl.power_down}, 32'h1);
        xfer(1'b0, 8'h40, 32'h0);
        chk({31'h0, errv}, 32'h1);
        chk(rdv, ACS_UNMAPPED_RDATA);
        xfer(1'b1, ACS_OFS_CTL, 32'h1);
        // Fourteen converter clocks of settling at the default divider of two
        repeat (28) @(posedge clk_sys_i);
        // Second pass recalibrates, as after a supply or temperature change
        for (int k = 0; k < 2; k++) begin
            xfer(1'b1, ACS_OFS_CTL, 32'h9);
            xfer(1'b0, ACS_OFS_CAL, 32'h0);
            chk(rdv, 32'h0);
            dly <= 5'($urandom_range(20, 8));
            xfer(1'b1, ACS_OFS_CTL, 32'h5);
            xfer(1'b0, ACS_OFS_CTL, 32'h0);
            chk({31'h0, rdv[2]}, 32'h1);
            poll(ACS_OFS_CTL, ACS_CTL_CAL_START_BIT, 1'b0);
            xfer(1'b0, ACS_OFS_CAL, 32'h0);
            chk(rdv, 32'h1);
        end
        for (int r = 0; r < 4; r++) begin
            xfer(1'b1, ACS_OFS_CTL, 32'h1 | (r << ACS_CTL_RES_LSB));
            repeat (2) @(posedge clk_sys_i);
            chk({30'h0, ctl.res}, r);
            xfer(1'b0, ACS_OFS_CTL, 32'h0);
            chk({30'h0, rdv[25:24]}, r);
        end
        for (int i = 0; i < 2; i++) begin
            len = (i == 0) ? 4'hf : 4'($urandom_range(14));
            xfer(1'b1, ACS_OFS_SEQ_FIRST, {8'h0, len, 20'h0});
            xfer(1'b0, ACS_OFS_SEQ_FIRST, 32'h0);
            chk({28'h0, rdv[23:20]}, {28'h0, len});
        end
        xfer(1'b1, ACS_OFS_OVS, 32'h11d);
        xfer(1'b0, ACS_OFS_OVS, 32'h0);
        chk({23'h0, rdv[8:0]}, 32'h11d);
        xfer(1'b1, ACS_OFS_OVS, 32'h0);
        for (int i = 0; i < 6; i++) begin
            ch = (i < 2) ? 5'(16 + i) : 5'($urandom_range(15));
            dly <= 5'($urandom_range(12, 1));
            xfer(1'b1, ACS_OFS_SEQ_THIRD, {27'h0, ch});
            xfer(1'b1, ACS_OFS_SEQ_FIRST, 32'h0);
            cw = 32'h21 | (32'(i % 2) << ACS_CTL_ALIGN_BIT) | (32'(i > 2) << 20);
            if (i > 2) begin
                xfer(1'b1, ACS_OFS_CTL, cw);
                hw_trigger_i <= 1'b1;
                repeat (3) @(posedge clk_sys_i);
                hw_trigger_i <= 1'b0;
            end else begin
                xfer(1'b1, ACS_OFS_CTL, cw | 32'h40_0000);
            end
            poll(ACS_OFS_STAT, ACS_STAT_EOC_BIT, 1'b1);
            chk({31'h0, irq_o}, 32'h1);
            xfer(1'b0, ACS_OFS_DATA, 32'h0);
            chk({16'h0, rdv[15:0]}, {16'h0, exp_data(ch, 1'(i % 2))});
            xfer(1'b1, ACS_OFS_STAT, 32'h0);
            @(posedge clk_sys_i);
            chk({31'h0, irq_o}, 32'h0);
        end
        repeat (40) @(posedge clk_sys_i);
        xfer(1'b0, ACS_OFS_STAT, 32'h0);
        chk({31'h0, rdv[1]}, 32'h0);
        // Two slots, four samples each, sum halved: the last slot reads twice its result
        xfer(1'b1, ACS_OFS_SEQ_THIRD, {22'h0, ch, ch ^ 5'h01});
        xfer(1'b1, ACS_OFS_SEQ_FIRST, 32'h0010_0000);
        xfer(1'b1, ACS_OFS_OVS, 32'h25);
        xfer(1'b1, ACS_OFS_CTL, 32'h40_0021);
        poll(ACS_OFS_STAT, ACS_STAT_EOC_BIT, 1'b1);
        xfer(1'b0, ACS_OFS_DATA, 32'h0);
        chk(rdv, {19'h0, ch, 7'h35, 1'b0});
        xfer(1'b1, ACS_OFS_STAT, 32'h0);
        // Continuous mode converts again with no further start
        xfer(1'b1, ACS_OFS_CTL, 32'h40_0023);
        poll(ACS_OFS_STAT, ACS_STAT_EOC_BIT, 1'b1);
        xfer(1'b1, ACS_OFS_STAT, 32'h0);
        poll(ACS_OFS_STAT, ACS_STAT_EOC_BIT, 1'b1);
        xfer(1'b1, ACS_OFS_CTL, 32'h0);
        repeat (3) @(posedge clk_sys_i);
        chk({31'h0, ctl.power_down}, 32'h1);
        xfer(1'b1, ACS_OFS_CTL, 32'h4);
        xfer(1'b0, ACS_OFS_CTL, 32'h0);
        chk(rdv, 32'h0);
        xfer(1'b0, ACS_OFS_CAL, 32'h0);
        chk(rdv, 32'h0);
        summarize();
    end
endmodule
bind acs_top acs_top_checker i_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .apb_req_i(apb_req_i), .apb_rsp_o(apb_rsp_o), .core_ctl_o(core_ctl_o),
    .core_rsp_i(core_rsp_i), .irq_o(irq_o));

// ### verilog/acs_pkg.sv
// Package for the converter control block: register map, fields, constants and types
package acs_pkg;
    // APB register byte offsets
    localparam logic [7:0] ACS_OFS_CTL = 8'h00;
    localparam logic [7:0] ACS_OFS_SEQ_FIRST = 8'h04;
    localparam logic [7:0] ACS_OFS_SEQ_SECOND = 8'h08;
    localparam logic [7:0] ACS_OFS_SEQ_THIRD = 8'h0c;
    localparam logic [7:0] ACS_OFS_OVS = 8'h10;
    localparam logic [7:0] ACS_OFS_STAT = 8'h14;
    localparam logic [7:0] ACS_OFS_DATA = 8'h18;
    localparam logic [7:0] ACS_OFS_CAL = 8'h1c;

    // Control register fields
    localparam int ACS_CTL_ON_BIT = 0;
    localparam int ACS_CTL_CONT_BIT = 1;
    localparam int ACS_CTL_CAL_START_BIT = 2;
    localparam int ACS_CTL_CAL_RESET_BIT = 3;
    localparam int ACS_CTL_ALIGN_BIT = 11;
    localparam int ACS_CTL_HWTRIG_EN_BIT = 20;
    localparam int ACS_CTL_SWSTART_BIT = 22;
    localparam int ACS_CTL_RES_LSB = 24;
    localparam int ACS_CTL_EOCIE_BIT = 5;
    localparam int ACS_CTL_WDIE_BIT = 6;
    localparam int ACS_CTL_WDEN_BIT = 23;

    // Sequence register fields
    localparam int ACS_SEQ_LEN_LSB = 20;
    localparam int ACS_CH_W = 5;
    localparam int ACS_SEQ_SLOTS = 16;
    localparam int ACS_CHANNELS = 18;

    // Oversampler fields
    localparam int ACS_OVS_EN_BIT = 0;
    localparam int ACS_OVS_RATIO_LSB = 2;
    localparam int ACS_OVS_SHIFT_LSB = 5;

    // Status fields
    localparam int ACS_STAT_WD_BIT = 0;
    localparam int ACS_STAT_EOC_BIT = 1;
    localparam int ACS_STAT_BUSY_BIT = 4;

    // Timing
    localparam int ACS_CLK_MHZ = 50;
    localparam int ACS_CAL_TIME_CYC = 16;
    localparam int ACS_CONV_TIME_CYC = 14;

    localparam logic [31:0] ACS_RST_VALUE = 32'h0000_0000;
    localparam logic [31:0] ACS_UNMAPPED_RDATA = 32'h0000_0000;

    typedef enum logic [1:0] {
        ACS_RES_12 = 2'b00,
        ACS_RES_10 = 2'b01,
        ACS_RES_8 = 2'b10,
        ACS_RES_6 = 2'b11
    } acs_res_type;

    typedef enum logic [1:0] {
        ACS_ST_OFF = 2'b00,
        ACS_ST_IDLE = 2'b01,
        ACS_ST_CAL = 2'b10,
        ACS_ST_CONV = 2'b11
    } acs_state_type;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } acs_apb_req_type;

    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } acs_apb_rsp_type;

    typedef struct packed {
        logic power_down;
        logic cal_run;
        logic cal_clear;
        logic sample;
        logic [ACS_CH_W-1:0] channel;
        acs_res_type res;
    } acs_core_ctl_type;

    typedef struct packed {
        logic done;
        logic [11:0] result;
    } acs_core_rsp_type;
endpackage

// ### verilog/acs_top.sv
// Converter control: enable, calibration, routine sequence, storage and oversampling
// Operation
// - Writing calibration start begins calibration
// - Start bit reads one until calibration ends
// - Calibration factor kept until power off
// - Calibration reset clears held calibration state
// - Enable low holds module in reset
// - Enable low powers down analog part
// - Routine sequence holds at most sixteen entries
// - Four-bit length field sets conversion count
// - Sixteen external plus two internal inputs
// - Resolution selectable as 12, 10, 8, 6
// - Results stored right or left aligned
// - Oversampler accumulates 2x to 256x, 16-bit
// - Oversampler right shift up to eight
// - Interrupt on sequence end and threshold
// - Start from software or hardware trigger
// - Single per trigger, continuous repeats itself
// - Converter clock is divided system clock
//
// Added by the designer: the register addresses and the APB interface to the registers.
module acs_top
    import acs_pkg::*;
#(
    parameter int CLK_DIV = 2,
    parameter logic [11:0] WD_HIGH = 12'hfff,
    parameter logic [11:0] WD_LOW = 12'h000
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire acs_pkg::acs_apb_req_type apb_req_i,
    output acs_pkg::acs_apb_rsp_type apb_rsp_o,
    input wire logic hw_trigger_i,
    output acs_pkg::acs_core_ctl_type core_ctl_o,
    input wire acs_pkg::acs_core_rsp_type core_rsp_i,
    output logic irq_o
);
    import acs_pkg::*;

    logic [31:0] ctl_q;
    logic [31:0] seq_q [3];
    logic [31:0] ovs_q;
    logic [15:0] data_q;
    logic eoc_q;
    logic wd_q;
    logic cal_valid_q;
    acs_state_type state_q;
    logic [3:0] slot_q;
    logic [7:0] ovs_cnt_q;
    logic [19:0] acc_q;
    logic [7:0] div_q;
    logic ck_en;
    logic [1:0] trig_sync_q;
    logic trig_prev_q;
    logic trig_rise;
    logic wr_en;
    logic rd_en;
    logic on;
    logic start_req;
    logic [4:0] slot_ch [ACS_SEQ_SLOTS];
    logic [3:0] seq_len;
    logic [8:0] ovs_ratio;
    logic [11:0] res_masked;
    logic [15:0] stored;
    logic [19:0] acc_next;
    logic [19:0] ovs_shifted;
    logic last_sample;

    assign on = ctl_q[ACS_CTL_ON_BIT];
    assign wr_en = apb_req_i.psel & apb_req_i.penable & apb_req_i.pwrite;
    assign rd_en = apb_req_i.psel & ~apb_req_i.pwrite;
    assign seq_len = seq_q[0][ACS_SEQ_LEN_LSB +: 4];
    assign ovs_ratio = 9'(2) << ovs_q[ACS_OVS_RATIO_LSB +: 3];

    // Converter clock enable; the divider runs off the system clock, so no crossing
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_q <= 8'h00;
        end else if (div_q >= 8'(CLK_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign ck_en = (div_q == 8'h00);

    // Trigger arrives from outside this domain
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            trig_sync_q <= 2'b00;
            trig_prev_q <= 1'b0;
        end else begin
            trig_sync_q <= {trig_sync_q[0], hw_trigger_i};
            trig_prev_q <= trig_sync_q[1];
        end
    end
    assign trig_rise = trig_sync_q[1] & ~trig_prev_q & ctl_q[ACS_CTL_HWTRIG_EN_BIT];
    assign start_req = ctl_q[ACS_CTL_SWSTART_BIT] | trig_rise;

    // Sequence slots: six channels per word, 16 slots in three words
    genvar gi;
    generate
        for (gi = 0; gi < ACS_SEQ_SLOTS; gi = gi + 1) begin : g_slot
            assign slot_ch[gi] = seq_q[2 - gi / 6][(gi % 6) * ACS_CH_W +: ACS_CH_W];
        end
    endgenerate

    // Control register; hardware clears the start bits
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctl_q <= ACS_RST_VALUE;
        end else begin
            if (wr_en && apb_req_i.paddr == ACS_OFS_CTL) begin
                ctl_q <= apb_req_i.pwdata;
                // A one written while calibrating keeps the bit set; zero is ignored
                ctl_q[ACS_CTL_CAL_START_BIT] <= ctl_q[ACS_CTL_CAL_START_BIT]
                    | (apb_req_i.pwdata[ACS_CTL_CAL_START_BIT]
                    & apb_req_i.pwdata[ACS_CTL_ON_BIT]);
            end else begin
                if (state_q == ACS_ST_CONV) begin
                    ctl_q[ACS_CTL_SWSTART_BIT] <= 1'b0;
                end
                ctl_q[ACS_CTL_CAL_RESET_BIT] <= 1'b0;
            end
            // Completion wins over a control write in the same cycle, or calibration reruns
            if (state_q == ACS_ST_CAL && core_rsp_i.done && ck_en) begin
                ctl_q[ACS_CTL_CAL_START_BIT] <= 1'b0;
            end
            if (!on) begin
                ctl_q[ACS_CTL_CAL_START_BIT] <= 1'b0;
                ctl_q[ACS_CTL_SWSTART_BIT] <= 1'b0;
            end
        end
    end

    // Sequence and oversampler configuration
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seq_q[0] <= ACS_RST_VALUE;
            seq_q[1] <= ACS_RST_VALUE;
            seq_q[2] <= ACS_RST_VALUE;
            ovs_q <= ACS_RST_VALUE;
        end else if (wr_en) begin
            case (apb_req_i.paddr)
                ACS_OFS_SEQ_FIRST: seq_q[0] <= apb_req_i.pwdata;
                ACS_OFS_SEQ_SECOND: seq_q[1] <= apb_req_i.pwdata;
                ACS_OFS_SEQ_THIRD: seq_q[2] <= apb_req_i.pwdata;
                ACS_OFS_OVS: ovs_q <= apb_req_i.pwdata;
                default: ;
            endcase
        end
    end

    // Main sequencer
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= ACS_ST_OFF;
            slot_q <= 4'h0;
        end else if (!on) begin
            state_q <= ACS_ST_OFF;
            slot_q <= 4'h0;
        end else begin
            case (state_q)
                ACS_ST_OFF: state_q <= ACS_ST_IDLE;
                ACS_ST_IDLE: begin
                    if (ctl_q[ACS_CTL_CAL_START_BIT]) begin
                        state_q <= ACS_ST_CAL;
                    end else if (start_req) begin
                        state_q <= ACS_ST_CONV;
                        slot_q <= 4'h0;
                    end
                end
                ACS_ST_CAL: begin
                    if (core_rsp_i.done && ck_en) begin
                        state_q <= ACS_ST_IDLE;
                    end
                end
                ACS_ST_CONV: begin
                    if (last_sample) begin
                        if (slot_q == seq_len) begin
                            slot_q <= 4'h0;
                            if (!ctl_q[ACS_CTL_CONT_BIT]) begin
                                state_q <= ACS_ST_IDLE;
                            end
                        end else begin
                            slot_q <= slot_q + 4'h1;
                        end
                    end
                end
                default: state_q <= ACS_ST_OFF;
            endcase
        end
    end

    // Calibration factor lives in the core; this flag tracks it until power off
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cal_valid_q <= 1'b0;
        end else if (!on || ctl_q[ACS_CTL_CAL_RESET_BIT]) begin
            cal_valid_q <= 1'b0;
        end else if (state_q == ACS_ST_CAL && core_rsp_i.done && ck_en) begin
            cal_valid_q <= 1'b1;
        end
    end

    // Resolution mask: lower bits dropped for shorter results
    always_comb begin
        case (acs_res_type'(ctl_q[ACS_CTL_RES_LSB +: 2]))
            ACS_RES_12: res_masked = core_rsp_i.result;
            ACS_RES_10: res_masked = {2'b00, core_rsp_i.result[11:2]};
            ACS_RES_8: res_masked = {4'h0, core_rsp_i.result[11:4]};
            ACS_RES_6: res_masked = {6'h00, core_rsp_i.result[11:6]};
            default: res_masked = core_rsp_i.result;
        endcase
    end

    assign acc_next = acc_q + {8'h00, res_masked};
    assign ovs_shifted = acc_next >> ovs_q[ACS_OVS_SHIFT_LSB +: 4];
    assign last_sample = state_q == ACS_ST_CONV && core_rsp_i.done && ck_en
        && (!ovs_q[ACS_OVS_EN_BIT] || {1'b0, ovs_cnt_q} == ovs_ratio - 9'h001);

    // Left alignment: 6-bit results align in the low byte, others in 16 bits
    always_comb begin
        if (ovs_q[ACS_OVS_EN_BIT]) begin
            stored = ovs_shifted[15:0];
        end else if (!ctl_q[ACS_CTL_ALIGN_BIT]) begin
            stored = {4'h0, res_masked};
        end else begin
            case (acs_res_type'(ctl_q[ACS_CTL_RES_LSB +: 2]))
                ACS_RES_10: stored = {res_masked[9:0], 6'h00};
                ACS_RES_8: stored = {res_masked[7:0], 8'h00};
                ACS_RES_6: stored = {8'h00, res_masked[5:0], 2'b00};
                default: stored = {res_masked, 4'h0};
            endcase
        end
    end

    // Oversampling accumulator
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            acc_q <= 20'h00000;
            ovs_cnt_q <= 8'h00;
        end else if (state_q != ACS_ST_CONV) begin
            acc_q <= 20'h00000;
            ovs_cnt_q <= 8'h00;
        end else if (core_rsp_i.done && ck_en) begin
            if (last_sample) begin
                acc_q <= 20'h00000;
                ovs_cnt_q <= 8'h00;
            end else begin
                acc_q <= acc_next;
                ovs_cnt_q <= ovs_cnt_q + 8'h01;
            end
        end
    end

    // Result and status flags; set wins over software clear
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            data_q <= 16'h0000;
            eoc_q <= 1'b0;
            wd_q <= 1'b0;
        end else if (!on) begin
            data_q <= 16'h0000;
            eoc_q <= 1'b0;
            wd_q <= 1'b0;
        end else begin
            if (wr_en && apb_req_i.paddr == ACS_OFS_STAT) begin
                eoc_q <= apb_req_i.pwdata[ACS_STAT_EOC_BIT] & eoc_q;
                wd_q <= apb_req_i.pwdata[ACS_STAT_WD_BIT] & wd_q;
            end
            if (last_sample) begin
                data_q <= stored;
                if (slot_q == seq_len) begin
                    eoc_q <= 1'b1;
                end
                if (ctl_q[ACS_CTL_WDEN_BIT]
                    && (core_rsp_i.result > WD_HIGH || core_rsp_i.result < WD_LOW)) begin
                    wd_q <= 1'b1;
                end
            end
        end
    end

    assign irq_o = (eoc_q & ctl_q[ACS_CTL_EOCIE_BIT])
        | (wd_q & ctl_q[ACS_CTL_WDIE_BIT]);

    // Core control; input select covers 18 channels
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            core_ctl_o <= '0;
            core_ctl_o.power_down <= 1'b1;
            core_ctl_o.cal_clear <= 1'b1;
        end else begin
            core_ctl_o.power_down <= ~on;
            // Gated by enable so no request outlives the power-down edge
            core_ctl_o.cal_run <= on && state_q == ACS_ST_CAL;
            core_ctl_o.cal_clear <= ctl_q[ACS_CTL_CAL_RESET_BIT] | ~on;
            core_ctl_o.sample <= on && state_q == ACS_ST_CONV;
            core_ctl_o.channel <= (slot_ch[slot_q] < 5'(ACS_CHANNELS))
                ? slot_ch[slot_q] : 5'h00;
            core_ctl_o.res <= acs_res_type'(ctl_q[ACS_CTL_RES_LSB +: 2]);
        end
    end

    // APB read mux; zero-wait slave
    always_comb begin
        apb_rsp_o.pready = 1'b1;
        apb_rsp_o.pslverr = 1'b0;
        apb_rsp_o.prdata = ACS_UNMAPPED_RDATA;
        if (rd_en) begin
            case (apb_req_i.paddr)
                ACS_OFS_CTL: apb_rsp_o.prdata = ctl_q;
                ACS_OFS_SEQ_FIRST: apb_rsp_o.prdata = seq_q[0];
                ACS_OFS_SEQ_SECOND: apb_rsp_o.prdata = seq_q[1];
                ACS_OFS_SEQ_THIRD: apb_rsp_o.prdata = seq_q[2];
                ACS_OFS_OVS: apb_rsp_o.prdata = ovs_q;
                ACS_OFS_STAT: apb_rsp_o.prdata = {27'h0, state_q == ACS_ST_CONV,
                    2'b00, eoc_q, wd_q};
                ACS_OFS_DATA: apb_rsp_o.prdata = {16'h0000, data_q};
                ACS_OFS_CAL: apb_rsp_o.prdata = {31'h0, cal_valid_q};
                default: apb_rsp_o.pslverr = apb_req_i.penable;
            endcase
        end
    end
endmodule
